// >>> core/ldf_pkg.sv
// Constants for the frame-one control/status logic of the load driver.
// Assumes a 200 MHz core clock and a 24-bit serial frame, MSB first.
package ldf_pkg;

   // Frame geometry
   localparam int FRAME_BITS      = 24;
   localparam int STAGES          = 17;
   localparam int OUTPUTS         = 11;

   // Control frame one fields
   localparam int CTRL_SELECT_BIT = 0;
   localparam int CTRL_PWM_LSB    = 1;
   localparam int CTRL_RECOV_LSB  = 12;
   localparam logic [23:0] CTRL_RESET = 24'h000000;

   // Status frame one fields
   localparam int STAT_NOERR_BIT  = 0;
   localparam int STAT_OL_LSB     = 1;
   localparam int STAT_MARK_BIT   = 23;
   localparam int STAT_ZERO_TOP   = 22;

   // Outputs gated from the second pulse input
   localparam int PWM_B_OUT_LO    = 9;
   localparam int PWM_B_OUT_HI    = 10;

   // Timing
   localparam int CLK_MHZ            = 200;
   localparam int OL_FILTER_US       = 1000;
   localparam int OL_FILTER_CYCLES   = OL_FILTER_US * CLK_MHZ;
   localparam int RECOV_SHORT_US     = 10;
   localparam int RECOV_LONG_US      = 20;
   localparam int RECOV_SHORT_CYCLES = RECOV_SHORT_US * CLK_MHZ;
   localparam int RECOV_LONG_CYCLES  = RECOV_LONG_US * CLK_MHZ;

   // Output number (1..11) driven by a stage (status bit = stage + 1)
   function automatic int stage_output(input int s);
      if (s < 10)
         return s / 2 + 1;
      else if (s == 10)
         return 6;
      else
         return s - 5;
   endfunction

endpackage

// >>> core/ldf_filt_if.sv
// Carries open-load filter inputs and flags between control and bank.
// Assumes all signals are on the core clock.
`timescale 1ns/10ps
interface ldf_filt_if;
   logic [16:0] active;
   logic [16:0] below;
   logic [16:0] clear;
   logic [16:0] flag;

   modport bank (input active, input below, input clear, output flag);
   modport ctrl (output active, output below, output clear, input flag);
endinterface

// >>> core/ldf_ol_bank.sv
// Open-load time filter, one counter per output stage.
// Assumes synchronised comparator levels and a one-cycle clear strobe.
`timescale 1ns/10ps
module ldf_ol_bank #(
   parameter int FILTER_CYCLES = ldf_pkg::OL_FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Filter channel
   ldf_filt_if.bank  filt
);

   typedef struct packed {
      logic [16:0][17:0] cnt;
      logic [16:0]       flag;
   } ldf_bank_state_type;

   ldf_bank_state_type state_reg;
   ldf_bank_state_type state_next;

   localparam logic [17:0] LIMIT = 18'(FILTER_CYCLES);

   // Counter restarts whenever the current rises or the stage drops
   always_comb
   begin
      state_next = state_reg;
      for (int s = 0; s < ldf_pkg::STAGES; s++)
      begin
         if (!filt.active[s] || !filt.below[s])
            state_next.cnt[s] = 18'h00000;
         else if (state_reg.cnt[s] != LIMIT)
            state_next.cnt[s] = state_reg.cnt[s] + 18'h00001;
         // Set wins over a clear in the same cycle
         state_next.flag[s] = (state_reg.flag[s] & ~filt.clear[s])
                            | (state_next.cnt[s] == LIMIT);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign filt.flag = state_reg.flag;

endmodule

// >>> core/ldf_frame_one.sv
// Frame-one control/status logic: serial slave, PWM gating, overcurrent
// recovery and open-load reporting. Assumes register-0 logic elsewhere
// supplies stage on bits, the duty bit and the frame-zero status word.
//
// Overview of operation
// - PWM-enabled switched-on output follows its pulse input
// - Outputs 9 and 10 use pulse input b
// - Open-load flag after 1 ms continuous low current
// - Status bits 17..1 map stages, high/low side
// - Status bit 0 is NOR of bits 1..22 of both status frames
// - Overcurrent sets flag and switches output off
// - Recovery re-enables after delay, duty from bit 21
// - Status bit 23 always reads one
`timescale 1ns/10ps
module ldf_frame_one #(
   parameter int OL_FILTER_CYCLES = ldf_pkg::OL_FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Serial link from the master
   input  wire logic        spi_csn_n_i,
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_mosi_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_n_o,
   // Pulse inputs
   input  wire logic        pulse_input_a_i,
   input  wire logic        pulse_input_b_i,
   // Register-0 side
   input  wire logic [16:0] stage_on_i,
   input  wire logic        duty_select_i,
   input  wire logic [23:0] status_zero_word_i,
   output logic [16:0]      overcurrent_flag_o,
   // Output stage comparators
   input  wire logic [16:0] load_below_ol_i,
   input  wire logic [16:0] overcurrent_i,
   // Output stage gates
   output logic [16:0]      stage_gate_o
);

   typedef struct packed {
      logic              cs_s1;
      logic              cs_s2;
      logic              cs_d;
      logic              sck_s1;
      logic              sck_s2;
      logic              sck_d;
      logic              mosi_s1;
      logic              mosi_s2;
      logic [1:0]        pwm_s1;
      logic [1:0]        pwm_s2;
      logic [16:0]       uc_s1;
      logic [16:0]       uc_s2;
      logic [16:0]       ovc_s1;
      logic [16:0]       ovc_s2;
      logic [23:0]       shift_in;
      logic [23:0]       shift_out;
      logic [4:0]        bitcnt;
      logic              sel_one;
      logic [23:0]       ctrl;
      logic              miso;
      logic              miso_oe_n;
      logic [16:0]       tripped;
      logic [16:0]       ocflag;
      logic [16:0][11:0] rcnt;
      logic [16:0]       gate;
      logic [16:0]       ol_clear;
      logic [16:0]       ol_seen;
   } ldf_top_state_type;

   ldf_top_state_type state_reg;
   ldf_top_state_type state_next;

   localparam logic [4:0]  FULL_COUNT = 5'(ldf_pkg::FRAME_BITS);
   localparam logic [11:0] RECOV_SHORT =
      12'(ldf_pkg::RECOV_SHORT_CYCLES - 1);
   localparam logic [11:0] RECOV_LONG =
      12'(ldf_pkg::RECOV_LONG_CYCLES - 1);

   ldf_filt_if filt ();

   logic [23:0] status_one;
   logic [11:0] recov_limit;

   // Open-load filters per stage
   ldf_ol_bank #(
      .FILTER_CYCLES (OL_FILTER_CYCLES)
   ) u_bank (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .filt  (filt)
   );

   // Filters watch stages that software has switched on and not tripped
   assign filt.active = stage_on_i & ~state_reg.tripped;
   assign filt.below  = state_reg.uc_s2;
   assign filt.clear  = state_reg.ol_clear;

   // Status frame one, built fresh at every frame start
   always_comb
   begin
      status_one = 24'h000000;
      status_one[ldf_pkg::STAT_MARK_BIT] = 1'b1;
      status_one[ldf_pkg::STAT_OL_LSB +: ldf_pkg::STAGES] =
         filt.flag;
      status_one[ldf_pkg::STAT_NOERR_BIT] =
         ~(|status_one[ldf_pkg::STAT_ZERO_TOP:1]
           | |status_zero_word_i[ldf_pkg::STAT_ZERO_TOP:1]);
   end

   // Duty bit picks the off time between retries
   assign recov_limit = duty_select_i ? RECOV_SHORT : RECOV_LONG;

   // Main next-state logic
   always_comb
   begin
      int o;
      logic pwm_src;
      o = 0;
      pwm_src = 1'b0;
      state_next = state_reg;

      // Two flops on every pin before use
      state_next.cs_s1   = spi_csn_n_i;
      state_next.cs_s2   = state_reg.cs_s1;
      state_next.cs_d    = state_reg.cs_s2;
      state_next.sck_s1  = spi_sclk_i;
      state_next.sck_s2  = state_reg.sck_s1;
      state_next.sck_d   = state_reg.sck_s2;
      state_next.mosi_s1 = spi_mosi_i;
      state_next.mosi_s2 = state_reg.mosi_s1;
      state_next.pwm_s1  = {pulse_input_b_i, pulse_input_a_i};
      state_next.pwm_s2  = state_reg.pwm_s1;
      state_next.uc_s1   = load_below_ol_i;
      state_next.uc_s2   = state_reg.uc_s1;
      state_next.ovc_s1  = overcurrent_i;
      state_next.ovc_s2  = state_reg.ovc_s1;
      state_next.ol_clear = 17'h00000;
      state_next.miso_oe_n = state_reg.cs_s2;

      // Serial frame: sample on rising, shift on falling clock edge
      if (state_reg.cs_d && !state_reg.cs_s2)
      begin
         state_next.shift_out = state_reg.sel_one ? status_one
                                                  : status_zero_word_i;
         state_next.miso   = state_next.shift_out[23];
         state_next.bitcnt = 5'h00;
         // Only flags shifted out now may be cleared at frame end
         state_next.ol_seen = filt.flag;
      end
      else if (!state_reg.cs_s2)
      begin
         if (state_reg.sck_s2 && !state_reg.sck_d)
         begin
            state_next.shift_in = {state_reg.shift_in[22:0],
                                   state_reg.mosi_s2};
            if (state_reg.bitcnt != 5'h1F)
               state_next.bitcnt = state_reg.bitcnt + 5'h01;
         end
         else if (!state_reg.sck_s2 && state_reg.sck_d)
         begin
            state_next.shift_out = {state_reg.shift_out[22:0], 1'b0};
            state_next.miso = state_reg.shift_out[22];
         end
      end
      else if (!state_reg.cs_d && state_reg.cs_s2)
      begin
         // Short or long frames are dropped whole
         if (state_reg.bitcnt == FULL_COUNT)
         begin
            if (state_reg.sel_one)
               state_next.ol_clear = state_reg.ol_seen;
            state_next.sel_one =
               state_reg.shift_in[ldf_pkg::CTRL_SELECT_BIT];
            if (state_reg.shift_in[ldf_pkg::CTRL_SELECT_BIT])
               state_next.ctrl = state_reg.shift_in;
         end
      end

      // Per stage: trip, recovery and gating
      for (int s = 0; s < ldf_pkg::STAGES; s++)
      begin
         o = ldf_pkg::stage_output(s);
         pwm_src = (o == ldf_pkg::PWM_B_OUT_LO || o == ldf_pkg::PWM_B_OUT_HI)
                 ? state_reg.pwm_s2[1] : state_reg.pwm_s2[0];
         if (!stage_on_i[s])
         begin
            state_next.tripped[s] = 1'b0;
            state_next.ocflag[s]  = 1'b0;
            state_next.rcnt[s]    = 12'h000;
         end
         else if (state_reg.tripped[s])
         begin
            // Without recovery the stage stays off until switched off
            if (state_reg.ctrl[ldf_pkg::CTRL_RECOV_LSB + o - 1])
            begin
               if (state_reg.rcnt[s] >= recov_limit)
               begin
                  state_next.tripped[s] = 1'b0;
                  state_next.rcnt[s]    = 12'h000;
               end
               else
                  state_next.rcnt[s] = state_reg.rcnt[s] + 12'h001;
            end
         end
         // Trip wins over any recovery in the same cycle
         if (stage_on_i[s] && state_reg.ovc_s2[s] && state_reg.gate[s])
         begin
            state_next.tripped[s] = 1'b1;
            state_next.ocflag[s]  = 1'b1;
            state_next.rcnt[s]    = 12'h000;
         end
         state_next.gate[s] = stage_on_i[s] & ~state_next.tripped[s]
            & (~state_reg.ctrl[ldf_pkg::CTRL_PWM_LSB + o - 1]
               | pwm_src);
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg           <= '0;
         state_reg.cs_s1     <= 1'b1;
         state_reg.cs_s2     <= 1'b1;
         state_reg.cs_d      <= 1'b1;
         state_reg.miso_oe_n <= 1'b1;
         state_reg.ctrl      <= ldf_pkg::CTRL_RESET;
      end
      else
         state_reg <= state_next;
   end

   // Outputs straight from flops
   assign spi_miso_o         = state_reg.miso;
   assign spi_miso_oe_n_o    = state_reg.miso_oe_n;
   assign overcurrent_flag_o = state_reg.ocflag;
   assign stage_gate_o       = state_reg.gate;

endmodule

// >>> test/ldf_frame_one_asserts.sv
// Port checker for the frame-one block.
// Assumes one core clock and a synchronous reset.
`timescale 1ns/10ps
module ldf_frame_one_asserts (
   // Watched ports
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        spi_csn_n_i,
   input wire logic        spi_miso_o,
   input wire logic        spi_miso_oe_n_o,
   input wire logic [16:0] stage_on_i,
   input wire logic [16:0] overcurrent_flag_o,
   input wire logic [16:0] stage_gate_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Select held long enough to pass the synchroniser
   sequence idle_s;
      spi_csn_n_i [*5];
   endsequence
   sequence busy_s;
      !spi_csn_n_i [*5];
   endsequence
   // Stage 0 trip is the watched overcurrent case
   sequence trip_s;
      $rose(overcurrent_flag_o[0]);
   endsequence
   gate_needs_on_a: assert property (
      (stage_gate_o & ~$past(stage_on_i)) == 17'h00000)
      else $error("gate on without stage on");
   trip_source_a: assert property (
      trip_s |-> $past(stage_gate_o[0])) else $error("trip of dark stage");
   trip_off_a: assert property (
      trip_s |-> ##[0:1] !stage_gate_o[0]) else $error("trip kept on");
   recov_wait_a: assert property (
      trip_s |=> ##1 !stage_gate_o[0] [*8]) else $error("early recovery");
   flag_keep_a: assert property (
      $fell(overcurrent_flag_o[0]) |-> !$past(stage_on_i[0]))
      else $error("flag lost while on");
   link_idle_a: assert property (
      idle_s |-> spi_miso_oe_n_o) else $error("drives while idle");
   link_busy_a: assert property (
      busy_s |-> !spi_miso_oe_n_o) else $error("no drive in frame");
   mark_bit_a: assert property (
      $fell(spi_miso_oe_n_o) |-> spi_miso_o) else $error("first bit low");
endmodule

// >>> test/ldf_spi_master.sv
// Serial master model: mode 0, MSB first, 80 ns clock.
// Assumes the caller runs one frame at a time.
`timescale 1ns/10ps
module ldf_spi_master (
   // Serial pins
   output logic      csn_n_o,
   output logic      sclk_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // Clock stands low outside frames
   initial
   begin
      csn_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
   end
   // One frame; bit 0 of w picks the register pair
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      // Pins move off the core clock edge
      #1;
      csn_n_o = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         mosi_o = w[i];
         #40;
         r[i] = miso_i;
         sclk_o = 1'b1;
         #40;
         sclk_o = 1'b0;
      end
      #40;
      csn_n_o = 1'b1;
      mosi_o = ~mosi_o; // Stale data must not look valid
      #100;
   endtask
   // Frame cut after n bits; the slave must drop it whole
   task automatic cut(input logic [23:0] w, input int n);
      #1;
      csn_n_o = 1'b0;
      for (int i = 23; i > 23 - n; i--)
      begin
         mosi_o = w[i];
         #40;
         sclk_o = 1'b1;
         #40;
         sclk_o = 1'b0;
      end
      #40;
      csn_n_o = 1'b1;
      #100;
   endtask
endmodule

// >>> test/ldf_frame_one_tb.sv
// Bench for the frame-one block with a serial master model.
// Assumes the master model owns the serial pins.
`timescale 1ns/10ps
module ldf_frame_one_tb;
   logic        clk_i, rst_i, duty, pa, pb;
   logic        spi_csn_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o;
   logic        spi_miso_oe_n_o;
   logic [16:0] on, below, ovc, gate, flag;
   logic [23:0] zw, rd, seen;
   logic [10:0] en;
   int          n_mismatch = 0;
   int          tests_run = 0;
   typedef struct {string nm; logic [23:0] v;} ldf_note_type;
   ldf_note_type q[$];
   event        got;

   // Short filter keeps the run brief
   ldf_frame_one #(.OL_FILTER_CYCLES(50)) DUT (.clk_i, .rst_i, .spi_csn_n_i,
      .spi_sclk_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_n_o,
      .pulse_input_a_i(pa), .pulse_input_b_i(pb), .stage_on_i(on),
      .duty_select_i(duty), .status_zero_word_i(zw), .load_below_ol_i(below),
      .overcurrent_i(ovc), .overcurrent_flag_o(flag), .stage_gate_o(gate));
   // Released line reads inverted, so a late drive shows as a bad bit
   ldf_spi_master MST (.csn_n_o(spi_csn_n_i), .sclk_o(spi_sclk_i),
      .mosi_o(spi_mosi_i),
      .miso_i(spi_miso_oe_n_o ? ~spi_miso_o : spi_miso_o));

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic check(string nm, logic [23:0] s, logic [23:0] e);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Note the expectation, then hand the result to the watcher
   task automatic post(string nm, logic [23:0] s, logic [23:0] e);
      q.push_back('{nm, e});
      seen = s;
      ->got;
      #1;
   endtask
   task automatic summarize;
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Gate of each stage: output index o, pulse b for outputs 9 and 10
   function automatic logic [16:0] egate(logic [10:0] e, logic a, logic b);
      int o;
      for (int s = 0; s < 17; s++)
      begin
         o = s < 10 ? s / 2 : (s == 10 ? 5 : s - 6);
         egate[s] = !e[o] || (o == 8 || o == 9 ? b : a);
      end
   endfunction
   // Watcher: oldest note against each result
   initial
   forever
   begin
      @got;
      check(q[0].nm, seen, q[0].v);
      q.delete(0);
   end
   initial
   begin
      tick(100000);
      n_mismatch++;
      summarize();
   end
   // Status words, open load per stage, gating, overcurrent recovery
   initial
   begin
      {rst_i, duty, pa, pb} = 4'h8;
      {on, below, ovc} = '0;
      zw = 24'h800000;
      void'($urandom(80));
      tick(12);
      rst_i <= 1'b0;
      tick(4);
      MST.xfer(24'h000001, rd);
      post("frame zero", rd, 24'h800000);
      MST.xfer(24'h000001, rd);
      post("idle status", rd, 24'h800001);
      tick(1);
      zw <= 24'h800000 | (24'h000002 << ($urandom % 22));
      MST.xfer(24'h000001, rd);
      post("no error", rd, 24'h800000);
      tick(1);
      zw <= 24'h800000;
      for (int s = 0; s < 17; s++)
      begin
         on <= 17'h00001 << s;
         below <= 17'h00001 << s;
         tick(80);
         below <= '0;
         MST.xfer(24'h000001, rd);
         post("open load", rd, 24'h800000 | 24'h000002 << s);
         MST.xfer(24'h000001, rd);
         post("read clear", rd, 24'h800001);
         tick(1);
      end
      for (int k = 0; k < 4; k++)
      begin
         en = 11'($urandom);
         MST.xfer({12'h000, en, 1'b1}, rd);
         tick(1);
         {on, pa, pb} <= {17'h1FFFF, 2'(k)};
         tick(10);
         post("gates", 24'(gate), 24'(egate(en, pa, pb)));
         // A cut frame must leave the enables as they were
         MST.cut({12'h000, 11'h7FF, 1'b1}, 23);
         post("cut frame", 24'(gate), 24'(egate(en, pa, pb)));
         tick(1);
      end
      for (int k = 0; k < 3; k++)
      begin
         MST.xfer({11'h000, k != 0, 12'h001}, rd);
         MST.xfer(24'h000000, rd);
         tick(1);
         {on, duty} <= {17'h00001, k == 2};
         tick(10);
         ovc <= 17'h00001;
         tick(10);
         ovc <= '0;
         post("trip flag", 24'(flag), 24'h000001);
         post("trip gate", 24'(gate), 24'h000000);
         tick(1880);
         post("off time", 24'(gate), 24'h000000);
         tick(200);
         post("short", 24'(gate), 24'(k == 2));
         tick(2000);
         post("long", 24'(gate), 24'(k != 0));
         tick(1);
         on <= '0;
         tick(5);
         post("flag clear", 24'(flag), 24'h000000);
      end
      summarize();
   end
endmodule

bind ldf_frame_one ldf_frame_one_asserts CHK (.clk_i, .rst_i, .spi_csn_n_i,
   .spi_miso_o, .spi_miso_oe_n_o, .stage_on_i, .overcurrent_flag_o,
   .stage_gate_o);
